// >>> design/timer_core_pkg.sv
// package: register map, field layout and reset values of the timer counter core
package timer_core_pkg;
	localparam logic [2:0] ADDR_STATUS_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_COUNT_HIGH     = 3'h1;
	localparam logic [2:0] ADDR_COUNT_LOW      = 3'h2;
	localparam logic [2:0] ADDR_LIMIT_HIGH     = 3'h3;
	localparam logic [2:0] ADDR_LIMIT_LOW      = 3'h4;
	localparam int SC_FLAG_BIT   = 7;
	localparam int SC_IRQEN_BIT  = 6;
	localparam int SC_CENTER_BIT = 5;
	localparam int SC_CLOCK_SOURCE_SELECT_LSB   = 3;
	localparam int SC_PS_LSB     = 0;
	localparam logic [1:0]  CLOCK_SOURCE_SELECT_NONE     = 2'h0;
	localparam logic [1:0]  CLOCK_SOURCE_SELECT_BUS      = 2'h1;
	localparam logic [1:0]  CLOCK_SOURCE_SELECT_FIXED    = 2'h2;
	localparam logic [1:0]  CLOCK_SOURCE_SELECT_EXTERNAL = 2'h3;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] LIMIT_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_MAX     = 16'hffff;
	localparam logic [6:0]  PRESCALE_RESET = 7'h00;
	localparam logic [7:0]  READ_UNMAPPED = 8'h00;
endpackage

// >>> design/timer_counter_core.sv
// timer counter core: clock select, prescaler, counter, wrap limit, overflow flag
`timescale 1ns/1ps
`default_nettype none

module timer_counter_core
	import timer_core_pkg::*;
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RESET_N_I,
	input  wire logic [2:0]  ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	input  wire logic        EXT_CLK_I,
	input  wire logic        FIXED_CLK_TICK_I,
	input  wire logic        FREQ_LOOP_ENABLED_I,
	input  wire logic        DEBUG_HALT_I,
	output logic             OVERFLOW_IRQ_O,
	output logic      [15:0] COUNT_O,
	output logic             COUNT_DOWN_O,
	output logic             CENTER_ALIGN_O
);

	logic        overflow_flag_r;
	logic        overflow_irq_enable_r;
	logic        center_align_select_r;
	logic [1:0]  clock_source_select_r;
	logic [2:0]  prescale_select_r;
	logic [15:0] count_r;
	logic        count_down_r;
	logic [15:0] limit_r;
	logic [7:0]  limit_buf_high_r;
	logic [7:0]  limit_buf_low_r;
	logic        limit_high_seen_r;
	logic        limit_low_seen_r;
	logic        limit_pending_r;
	logic [7:0]  count_latch_high_r;
	logic [7:0]  count_latch_low_r;
	logic        count_latched_r;
	logic        clear_armed_r;
	logic [2:0]  ext_sync_r;
	logic        ext_level_r;
	logic        ext_level_d_r;
	logic [6:0]  prescale_cnt_r;
	logic [6:0]  prescale_cnt_nxt;
	logic [7:0]  rdata_r;

	logic        wr_sc;
	logic        wr_count;
	logic        wr_limit_high;
	logic        wr_limit_low;
	logic        rd_sc;
	logic        rd_count_high;
	logic        rd_count_low;
	logic        source_tick;
	logic        timer_tick;
	logic        at_limit;
	logic        wrap_event;
	logic        overflow_event;
	logic        limit_step;
	logic [6:0]  prescale_mask;
	logic [15:0] limit_eff;

	assign wr_sc         = WR_I && (ADDR_I == ADDR_STATUS_CONTROL);
	assign wr_count      = WR_I && (ADDR_I == ADDR_COUNT_HIGH || ADDR_I == ADDR_COUNT_LOW);
	assign wr_limit_high = WR_I && (ADDR_I == ADDR_LIMIT_HIGH);
	assign wr_limit_low  = WR_I && (ADDR_I == ADDR_LIMIT_LOW);
	assign rd_sc         = RD_I && (ADDR_I == ADDR_STATUS_CONTROL);
	assign rd_count_high = RD_I && (ADDR_I == ADDR_COUNT_HIGH);
	assign rd_count_low  = RD_I && (ADDR_I == ADDR_COUNT_LOW);

	// external clock: three stages, an edge counts once stages two and three agree
	// the pin must stay below a quarter of the bus rate or edges are lost
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ext_sync_r <= 3'h0;
		end else begin
			ext_sync_r <= {ext_sync_r[1:0], EXT_CLK_I};
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ext_level_r   <= 1'b0;
			ext_level_d_r <= 1'b0;
		end else begin
			if (ext_sync_r[1] == ext_sync_r[2]) begin
				ext_level_r <= ext_sync_r[2];
			end
			ext_level_d_r <= ext_level_r;
		end
	end

	// source selection ahead of the prescaler
	always_comb begin
		case (clock_source_select_r)
			CLOCK_SOURCE_SELECT_NONE: begin
				source_tick = 1'b0;
			end
			CLOCK_SOURCE_SELECT_BUS: begin
				source_tick = 1'b1;
			end
			CLOCK_SOURCE_SELECT_FIXED: begin
				// without an enabled loop the fixed clock is the bus clock
				source_tick = FREQ_LOOP_ENABLED_I ? FIXED_CLK_TICK_I : 1'b1;
			end
			CLOCK_SOURCE_SELECT_EXTERNAL: begin
				source_tick = ext_level_r && !ext_level_d_r;
			end
			default: begin
				source_tick = 1'b0;
			end
		endcase
	end

	// mask is formed from the stored field, so a new value acts on the next cycle
	// prescaler phase survives register writes, so the first tick after a change may come early
	assign prescale_mask = 7'((8'h01 << prescale_select_r) - 8'h01);
	assign timer_tick    = source_tick && !DEBUG_HALT_I
		&& ((prescale_cnt_r & prescale_mask) == prescale_mask);

	always_comb begin
		prescale_cnt_nxt = prescale_cnt_r;
		if (source_tick && !DEBUG_HALT_I) begin
			prescale_cnt_nxt = 7'(prescale_cnt_r + 7'h01);
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			prescale_cnt_r <= PRESCALE_RESET;
		end else begin
			prescale_cnt_r <= prescale_cnt_nxt;
		end
	end

	// a zero limit means free running over the whole range
	assign limit_eff = (limit_r == LIMIT_RESET) ? COUNT_MAX : limit_r;
	assign at_limit  = (count_r == limit_eff);
	// judged against the limit in force, so a free running counter loads at the top
	assign limit_step = timer_tick && !count_down_r
		&& (count_r == 16'(limit_eff - 16'h0001));

	always_comb begin
		wrap_event = 1'b0;
		if (timer_tick) begin
			if (center_align_select_r) begin
				wrap_event = count_down_r && (count_r == 16'h0001);
			end else begin
				wrap_event = at_limit;
			end
		end
	end
	assign overflow_event = wrap_event && !limit_pending_r;

	// counter and direction
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			count_r      <= COUNT_RESET;
			count_down_r <= 1'b0;
		end else if (wr_count) begin
			count_r      <= COUNT_RESET;
			count_down_r <= 1'b0;
		end else if (timer_tick) begin
			if (!center_align_select_r) begin
				count_down_r <= 1'b0;
				count_r      <= at_limit ? COUNT_RESET : 16'(count_r + 16'h0001);
			end else if (!count_down_r) begin
				if (at_limit) begin
					count_down_r <= 1'b1;
					count_r      <= 16'(count_r - 16'h0001);
				end else begin
					count_r <= 16'(count_r + 16'h0001);
				end
			end else begin
				if (count_r == 16'h0001 || count_r == COUNT_RESET) begin
					count_down_r <= 1'b0;
				end
				count_r <= (count_r == COUNT_RESET) ? 16'h0001 : 16'(count_r - 16'h0001);
			end
		end
	end

	// control fields, one register each
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			overflow_irq_enable_r <= 1'b0;
		end else if (wr_sc) begin
			overflow_irq_enable_r <= WDATA_I[SC_IRQEN_BIT];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			center_align_select_r <= 1'b0;
		end else if (wr_sc) begin
			center_align_select_r <= WDATA_I[SC_CENTER_BIT];
		end
	end

	// source 00 stops the counter; a limit pair then loads at once, but a write here drops a pending one
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			clock_source_select_r <= CLOCK_SOURCE_SELECT_NONE;
		end else if (wr_sc) begin
			clock_source_select_r <= WDATA_I[SC_CLOCK_SOURCE_SELECT_LSB +: 2];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			prescale_select_r <= 3'h0;
		end else if (wr_sc) begin
			prescale_select_r <= WDATA_I[SC_PS_LSB +: 3];
		end
	end

	// overflow flag; a fresh overflow always beats the clear
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			overflow_flag_r <= 1'b0;
			clear_armed_r   <= 1'b0;
		end else if (overflow_event) begin
			overflow_flag_r <= 1'b1;
			clear_armed_r   <= 1'b0;
		end else begin
			if (rd_sc && overflow_flag_r) begin
				clear_armed_r <= 1'b1;
			end
			if (wr_sc && !WDATA_I[SC_FLAG_BIT] && clear_armed_r) begin
				overflow_flag_r <= 1'b0;
				clear_armed_r   <= 1'b0;
			end
		end
	end

	assign OVERFLOW_IRQ_O = overflow_flag_r && overflow_irq_enable_r;

	// counter read latch; reads leave it alone while halted, control or count writes still release it
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			count_latched_r    <= 1'b0;
			count_latch_high_r <= 8'h00;
			count_latch_low_r  <= 8'h00;
		end else if (wr_sc || wr_count) begin
			count_latched_r <= 1'b0;
		end else if (!DEBUG_HALT_I && (rd_count_high || rd_count_low)) begin
			if (!count_latched_r) begin
				count_latched_r    <= 1'b1;
				count_latch_high_r <= count_r[15:8];
				count_latch_low_r  <= count_r[7:0];
			end else begin
				count_latched_r <= 1'b0;
			end
		end
	end

	// limit write buffering
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			limit_r           <= LIMIT_RESET;
			limit_buf_high_r  <= 8'h00;
			limit_buf_low_r   <= 8'h00;
			limit_high_seen_r <= 1'b0;
			limit_low_seen_r  <= 1'b0;
			limit_pending_r   <= 1'b0;
		end else if (wr_sc) begin
			limit_high_seen_r <= 1'b0;
			limit_low_seen_r  <= 1'b0;
			limit_pending_r   <= 1'b0;
		end else if (DEBUG_HALT_I) begin
			if (wr_limit_high) begin
				limit_r[15:8] <= WDATA_I;
			end
			if (wr_limit_low) begin
				limit_r[7:0] <= WDATA_I;
			end
		end else if (wr_limit_high || wr_limit_low) begin
			if (wr_limit_high) begin
				limit_buf_high_r <= WDATA_I;
			end else begin
				limit_buf_low_r <= WDATA_I;
			end
			if ((wr_limit_high && limit_low_seen_r) || (wr_limit_low && limit_high_seen_r)) begin
				limit_high_seen_r <= 1'b0;
				limit_low_seen_r  <= 1'b0;
				if (clock_source_select_r == CLOCK_SOURCE_SELECT_NONE) begin
					limit_r         <= wr_limit_high ? {WDATA_I, limit_buf_low_r}
						: {limit_buf_high_r, WDATA_I};
					limit_pending_r <= 1'b0;
				end else begin
					limit_pending_r <= 1'b1;
				end
			end else begin
				limit_high_seen_r <= wr_limit_high;
				limit_low_seen_r  <= wr_limit_low;
				limit_pending_r   <= 1'b1;
			end
		end else if (limit_pending_r && !limit_high_seen_r && !limit_low_seen_r) begin
			if (clock_source_select_r == CLOCK_SOURCE_SELECT_NONE) begin
				limit_r         <= {limit_buf_high_r, limit_buf_low_r};
				limit_pending_r <= 1'b0;
			end else if (limit_step) begin
				limit_r         <= {limit_buf_high_r, limit_buf_low_r};
				limit_pending_r <= 1'b0;
			end
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_r <= 8'h00;
		end else if (RD_I) begin
			case (ADDR_I)
				ADDR_STATUS_CONTROL: begin
					rdata_r <= {overflow_flag_r, overflow_irq_enable_r, center_align_select_r,
						clock_source_select_r, prescale_select_r};
				end
				ADDR_COUNT_HIGH: begin
					rdata_r <= count_latched_r ? count_latch_high_r : count_r[15:8];
				end
				ADDR_COUNT_LOW: begin
					rdata_r <= count_latched_r ? count_latch_low_r : count_r[7:0];
				end
				ADDR_LIMIT_HIGH: begin
					rdata_r <= limit_r[15:8];
				end
				ADDR_LIMIT_LOW: begin
					rdata_r <= limit_r[7:0];
				end
				default: begin
					rdata_r <= READ_UNMAPPED;
				end
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign RDATA_O        = rdata_r;
	assign COUNT_O        = count_r;
	assign COUNT_DOWN_O   = count_down_r;
	assign CENTER_ALIGN_O = center_align_select_r;

endmodule

`default_nettype wire

// >>> verification/timer_core_assertions.sv
// checker: port-level timing rules of the timer counter core
`timescale 1ns/1ps
`default_nettype none
module timer_core_chk
	import timer_core_pkg::*;
(
	input wire logic        CLK_SYS_I,
	input wire logic        RESET_N_I,
	input wire logic [2:0]  ADDR_I,
	input wire logic [7:0]  WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [7:0]  RDATA_O,
	input wire logic        FREQ_LOOP_ENABLED_I,
	input wire logic        DEBUG_HALT_I,
	input wire logic        OVERFLOW_IRQ_O,
	input wire logic [15:0] COUNT_O,
	input wire logic        CENTER_ALIGN_O
);
	logic [7:0] sc_r;
	logic       sc_wr;
	logic       bus_run;
	logic       cnt_wr;
	assign sc_wr = WR_I && ADDR_I == ADDR_STATUS_CONTROL;
	assign cnt_wr = WR_I && (ADDR_I == ADDR_COUNT_HIGH || ADDR_I == ADDR_COUNT_LOW);
	assign bus_run = sc_r[4:3] == CLOCK_SOURCE_SELECT_BUS || (sc_r[4:3] == CLOCK_SOURCE_SELECT_FIXED && !FREQ_LOOP_ENABLED_I);
	// shadow of the whole written byte; its bit 7 is not the flag, which cannot be rebuilt from ports
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			sc_r <= 8'h00;
		else if (sc_wr)
			sc_r <= WDATA_I;
	end
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_flag_read;
		RD_I && ADDR_I == ADDR_STATUS_CONTROL ##1 RDATA_O[SC_FLAG_BIT];
	endsequence
	sequence s_clear_wr;
		sc_wr && !WDATA_I[SC_FLAG_BIT] && sc_r[4:3] == CLOCK_SOURCE_SELECT_NONE;
	endsequence
	chk_ctrl_readback: assert property (RD_I && ADDR_I == ADDR_STATUS_CONTROL
		|=> RDATA_O[6:0] == $past(sc_r[6:0])) else $error("control bits read back wrong");
	chk_count_clear: assert property (cnt_wr |=> COUNT_O == 16'h0000)
		else $error("count write did not clear counter");
	chk_halt_freeze: assert property (DEBUG_HALT_I && !cnt_wr |=> $stable(COUNT_O))
		else $error("counter moved during halt");
	chk_stop_hold: assert property (sc_r[4:3] == CLOCK_SOURCE_SELECT_NONE && !cnt_wr |=> $stable(COUNT_O))
		else $error("counter moved with no clock");
	chk_irq_masked: assert property (!sc_r[SC_IRQEN_BIT] |-> !OVERFLOW_IRQ_O)
		else $error("interrupt without enable");
	chk_bus_step: assert property (bus_run && !sc_r[5] && sc_r[2:0] == 3'h0
		&& !DEBUG_HALT_I
		&& !cnt_wr |=> COUNT_O == $past(COUNT_O) + 16'h0001 || COUNT_O == 16'h0000)
		else $error("bus clock step wrong");
	chk_center_out: assert property (sc_wr |=> CENTER_ALIGN_O == $past(WDATA_I[5]))
		else $error("center select output wrong");
	chk_flag_clear: assert property (s_flag_read ##1 s_clear_wr |=> !OVERFLOW_IRQ_O)
		else $error("flag not cleared by read then write");
endmodule
bind timer_counter_core timer_core_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.FREQ_LOOP_ENABLED_I(FREQ_LOOP_ENABLED_I), .DEBUG_HALT_I(DEBUG_HALT_I),
	.OVERFLOW_IRQ_O(OVERFLOW_IRQ_O), .COUNT_O(COUNT_O), .CENTER_ALIGN_O(CENTER_ALIGN_O));
`default_nettype wire

// >>> verification/tb.sv
// testbench: register-level scenarios for the timer counter core
`timescale 1ns/1ps
`default_nettype none
module tb;
	import timer_core_pkg::*;
	localparam logic [2:0] SC = ADDR_STATUS_CONTROL;
	localparam logic [2:0] CH = ADDR_COUNT_HIGH;
	localparam logic [2:0] CL = ADDR_COUNT_LOW;
	localparam logic [2:0] LH = ADDR_LIMIT_HIGH;
	localparam logic [2:0] LL = ADDR_LIMIT_LOW;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  ad = 3'h0;
	logic [7:0]  wd = 8'h00;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic        ext = 1'b0;
	logic        fix = 1'b0;
	logic        loop_en = 1'b0;
	logic        halt = 1'b0;
	logic        re_d = 1'b0;
	logic [7:0]  rdata;
	logic        irq;
	logic [15:0] cnt;
	logic        down;
	logic        center;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	int          miscompares = 0;
	int          n_compared = 0;
	int          seed = 32'h99d9;
	always #12.5 clk = ~clk;
	timer_counter_core DUT (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .ADDR_I(ad), .WDATA_I(wd),
		.WR_I(we), .RD_I(re), .RDATA_O(rdata), .EXT_CLK_I(ext), .FIXED_CLK_TICK_I(fix),
		.FREQ_LOOP_ENABLED_I(loop_en), .DEBUG_HALT_I(halt), .OVERFLOW_IRQ_O(irq),
		.COUNT_O(cnt), .COUNT_DOWN_O(down), .CENTER_ALIGN_O(center));
	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] m);
		exp_q.push_back({m, d});
		@(posedge clk);
		ad <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		@(negedge clk);
	endtask
	// ext edges spaced well under a quarter of the bus rate, then sync latency
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk);
			ext <= 1'b1;
			repeat (4) @(posedge clk);
			ext <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (6) @(negedge clk);
	endtask
	task automatic wait_irq;
		int i;
		for (i = 0; i < 200 && irq !== 1'b1; i++)
			@(negedge clk);
		if (i == 200) begin
			miscompares++;
			$display("ERROR irq wait expired");
			close_out;
		end
	endtask
	always @(posedge clk)
		re_d <= re;
	always @(negedge clk) begin
		if (re_d) begin
			e = exp_q.pop_front();
			check("rdata", rdata & e[15:8], e[7:0]);
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(SC, 8'h00, 8'hff);
		rd(CL, 8'h00, 8'hff);
		rd(CH, 8'h00, 8'hff);
		rd(LH, 8'h00, 8'hff);
		rd(LL, 8'h00, 8'hff);
		rd(3'h7, READ_UNMAPPED, 8'hff);
		$display("test reset done");
		wr(LH, 8'h00);
		wr(LL, 8'h05);
		rd(LL, 8'h05, 8'hff);
		wr(SC, 8'h48);
		wait_irq;
		check("wrap", cnt, 16'h0000);
		wr(SC, 8'h40);
		wr(SC, 8'h40);
		check("irq", irq, 1'b1);
		rd(SC, 8'hc0, 8'hff);
		wr(SC, 8'hc0);
		check("irq", irq, 1'b1);
		rd(SC, 8'hc0, 8'hff);
		wr(SC, 8'h40);
		check("irq", irq, 1'b0);
		wr(SC, 8'h48);
		wait_irq;
		rd(SC, 8'hc8, 8'hff);
		repeat (8) @(negedge clk);
		wr(SC, 8'h48);
		check("irq", irq, 1'b1);
		$display("test flag done");
		wr(SC, 8'h00);
		wr(LH, 8'h00);
		wr(LL, 8'h00);
		wr(SC, 8'h18);
		wr(CH, 8'($random(seed)));
		check("cnt", cnt, 16'h0000);
		pulse(300);
		check("cnt", cnt, 16'd300);
		rd(CL, 8'h2c, 8'hff);
		pulse(300);
		rd(CH, 8'h01, 8'hff);
		rd(CH, 8'h02, 8'hff);
		rd(CL, 8'h58, 8'hff);
		rd(CL, 8'h58, 8'hff);
		pulse(300);
		wr(SC, 8'h18);
		rd(CH, 8'h03, 8'hff);
		@(posedge clk);
		halt <= 1'b1;
		pulse(20);
		check("cnt", cnt, 16'd900);
		rd(CL, 8'h84, 8'hff);
		wr(LL, 8'h07);
		rd(LL, 8'h07, 8'hff);
		wr(LL, 8'h00);
		@(posedge clk);
		halt <= 1'b0;
		pulse(4);
		rd(CL, 8'h84, 8'hff);
		rd(CL, 8'h88, 8'hff);
		$display("test count done");
		wr(CL, 8'($random(seed)));
		for (int i = 0; i < 8; i++) begin
			wr(SC, 8'(8'h18 + i));
			pulse(2 << i);
			check("cnt", cnt, 16'(2 * (i + 1)));
		end
		wr(CL, 8'($random(seed)));
		@(posedge clk);
		loop_en <= 1'b1;
		wr(SC, 8'h10);
		repeat (5) begin
			@(posedge clk);
			fix <= 1'b1;
			@(posedge clk);
			fix <= 1'b0;
		end
		@(negedge clk);
		check("cnt", cnt, 16'd5);
		@(posedge clk);
		loop_en <= 1'b0;
		repeat (20) @(posedge clk);
		wr(SC, 8'h00);
		check("fixbus", cnt > 16'd24, 1'b1);
		$display("test source done");
		rd(SC, 8'h80, 8'hff);
		wr(SC, 8'h00);
		rd(SC, 8'h00, 8'hff);
		wr(LH, 8'h00);
		wr(SC, 8'h00);
		wr(LL, 8'h06);
		rd(LL, 8'h00, 8'hff);
		wr(LH, 8'h00);
		rd(LL, 8'h06, 8'hff);
		wr(SC, 8'h58);
		wr(CH, 8'($random(seed)));
		wr(LH, 8'h00);
		wr(LL, 8'h0a);
		rd(LL, 8'h06, 8'hff);
		pulse(20);
		check("cnt", cnt, 16'd9);
		check("irq", irq, 1'b1);
		rd(SC, 8'hd8, 8'hff);
		wr(SC, 8'h58);
		wr(LH, 8'h00);
		pulse(11);
		check("irq", irq, 1'b0);
		wr(LL, 8'h0a);
		pulse(2);
		check("irq", irq, 1'b1);
		wr(SC, 8'h18);
		wr(CL, 8'h00);
		wr(SC, 8'h38);
		pulse(13);
		check("cnt", cnt, 16'd7);
		check("down", down, 1'b1);
		check("center", center, 1'b1);
		$display("test limit done");
		repeat (2) @(negedge clk);
		close_out;
	end
endmodule
`default_nettype wire
